// *** logic/rhc_defines.svh ***
`ifndef RHC_DEFINES_SVH
`define RHC_DEFINES_SVH

// clock rate and documented times
`define RHC_CLK_KHZ        20000
`define RHC_HB_MS          5
`define RHC_MSG_MS         100
`define RHC_MSG_TO_MS      250
`define RHC_HS_TO_MS       25
`define RHC_SETTLE_MS      200
`define RHC_RELEASE_MS     300

// cycle counts derived from the times (least times, exact at 20 MHz)
`define RHC_HB_CYC         (`RHC_HB_MS * `RHC_CLK_KHZ)
`define RHC_MSG_CYC        (`RHC_MSG_MS * `RHC_CLK_KHZ)
`define RHC_MSG_TO_CYC     (`RHC_MSG_TO_MS * `RHC_CLK_KHZ)
`define RHC_HS_TO_CYC      (`RHC_HS_TO_MS * `RHC_CLK_KHZ)
`define RHC_SETTLE_CYC     (`RHC_SETTLE_MS * `RHC_CLK_KHZ)
`define RHC_RELEASE_CYC    (`RHC_RELEASE_MS * `RHC_CLK_KHZ)

// serial link framing: start, role, state, anomalies, stop
`define RHC_BIT_CYC        16'h07d0
`define RHC_HALF_BIT_CYC   16'h03e8
`define RHC_FRAME_BITS     5'h14
`define RHC_STOP_IDX       5'h13
`define RHC_ANOM_W         16

// register byte offsets
`define RHC_OFS_CTRL       8'h00
`define RHC_OFS_ANOM_SELF  8'h04
`define RHC_OFS_ANOM_LOCAL 8'h08
`define RHC_OFS_STATUS     8'h0c
`define RHC_OFS_ANOM_RX    8'h10

// status field positions
`define RHC_ST_CMD         0
`define RHC_ST_RELAY       1
`define RHC_ST_IO          2
`define RHC_ST_RLY_FAULT   3
`define RHC_ST_SEC_FAIL    4
`define RHC_ST_MSG_FAIL    5
`define RHC_ST_HS_FAIL     6
`define RHC_ST_PEER_CMD    7
`define RHC_ST_PEER_BKP    8

`endif

// *** logic/rhc_pkg.sv ***
package rhc_pkg;
  // wide enough for the longest (300 ms) count
  typedef logic [23:0] rhc_cnt_t;
  typedef logic [15:0] rhc_anom_t;
  typedef enum logic [1:0] {
    RHC_WATCH,
    RHC_SETTLE,
    RHC_COMMAND,
    RHC_RELEASE
  } rhc_role_e;
endpackage

// *** logic/rhc_timer.sv ***
module rhc_timer (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             start_i,
  input  rhc_pkg::rhc_cnt_t     load_i,
  output logic                  busy_o,
  output logic                  done_o
);
  rhc_pkg::rhc_cnt_t cnt_q;
  rhc_pkg::rhc_cnt_t cnt_d;

  // restart wins over the running count
  assign busy_o = (cnt_q != '0);
  assign done_o = (cnt_q == rhc_pkg::rhc_cnt_t'(1));
  assign cnt_d  = start_i ? load_i : (busy_o ? cnt_q - rhc_pkg::rhc_cnt_t'(1) : cnt_q);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

// *** logic/rhc_top.sv ***
// Overview of operation
// - secondary never hands control back to primary without operator request
// - one push-button request wired to both units' digital input
// - secondary drops relay command on request, returning all switched I/O
// - secondary runs 300 ms timer, then flags relay fault on wrong feedback
// - secondary changes commanding to watching when 300 ms timer expires
// - primary assumes relay released on request, no link confirmation needed
// - primary starts 200 ms settling timer, switched I/O unused meanwhile
// - after settling primary controls, transmits fieldbus, flags bad feedback
// - primary flags secondary failure: link lost while feedback shows secondary
// - commanding unit sends its anomalies; watching unit keeps them undisplayed
// - watching unit keeps self-raised anomaly set, which is displayed
// - on becoming commanding, drop self set, adopt received set
// - toggle handshake every 5 ms, send role/state message every 100 ms
// - peer failed after 250 ms without message or 25 ms without toggle
// - new commander waits 200 ms after relay change before using I/O
`include "rhc_defines.svh"
module rhc_top #(
  parameter rhc_pkg::rhc_cnt_t P_HB_CYC      = rhc_pkg::rhc_cnt_t'(`RHC_HB_CYC),
  parameter rhc_pkg::rhc_cnt_t P_MSG_CYC     = rhc_pkg::rhc_cnt_t'(`RHC_MSG_CYC),
  parameter rhc_pkg::rhc_cnt_t P_MSG_TO_CYC  = rhc_pkg::rhc_cnt_t'(`RHC_MSG_TO_CYC),
  parameter rhc_pkg::rhc_cnt_t P_HS_TO_CYC   = rhc_pkg::rhc_cnt_t'(`RHC_HS_TO_CYC),
  parameter rhc_pkg::rhc_cnt_t P_SETTLE_CYC  = rhc_pkg::rhc_cnt_t'(`RHC_SETTLE_CYC),
  parameter rhc_pkg::rhc_cnt_t P_RELEASE_CYC = rhc_pkg::rhc_cnt_t'(`RHC_RELEASE_CYC)
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  input  wire logic        handover_to_primary_request_i,
  input  wire logic        relay_fb_i,
  input  wire logic        handshake_i,
  input  wire logic        link_rx_i,
  output logic             handshake_o,
  output logic             link_tx_o,
  output logic             changeover_relay_command_o,
  output logic             io_enable_o,
  output logic             fieldbus_tx_en_o,
  output logic             relay_feedback_fault_warning_o,
  output logic             secondary_unit_failure_warning_o,
  output rhc_pkg::rhc_anom_t display_anom_o
);
  rhc_pkg::rhc_role_e state_q;
  rhc_pkg::rhc_role_e state_d;
  rhc_pkg::rhc_anom_t anom_self_q;
  rhc_pkg::rhc_anom_t anom_local_q;
  rhc_pkg::rhc_anom_t anom_rx_q;
  logic        role_bkp_q;
  logic        init_q;
  logic        startup_q;
  logic        req_q;
  logic        hs_in_q;
  logic        hs_out_q;
  logic        relay_q;
  logic        rly_fault_q;
  logic        sec_fail_q;
  logic        msg_fail_q;
  logic        hs_fail_q;
  logic        peer_cmd_q;
  logic        peer_bkp_q;
  logic        rx_seen_q;
  logic        dp_wr_q;
  logic [7:0]  dp_addr_q;
  logic [31:0] rdata_q;
  logic [19:0] tx_sh_q;
  logic [4:0]  tx_left_q;
  logic [15:0] tx_cyc_q;
  logic        rx_busy_q;
  logic [4:0]  rx_idx_q;
  logic [15:0] rx_cyc_q;
  logic [17:0] rx_sh_q;

  // bus decode: zero wait, always OKAY
  wire         addr_ph  = hsel_i & hready_i & htrans_i[1];
  wire         in_map   = addr_ph & (haddr_i[31:8] == 24'h000000);
  wire [7:0]   rd_addr  = in_map ? haddr_i[7:0] : 8'hff;
  wire         wr_ctrl  = dp_wr_q & (dp_addr_q == `RHC_OFS_CTRL);
  wire         wr_self  = dp_wr_q & (dp_addr_q == `RHC_OFS_ANOM_SELF);
  wire         wr_local = dp_wr_q & (dp_addr_q == `RHC_OFS_ANOM_LOCAL);
  wire         wr_stat  = dp_wr_q & (dp_addr_q == `RHC_OFS_STATUS);
  wire         clr_rf   = wr_stat & hwdata_i[`RHC_ST_RLY_FAULT];
  wire         clr_sf   = wr_stat & hwdata_i[`RHC_ST_SEC_FAIL];
  wire [31:0]  status_w;
  wire [31:0]  rd_mux;

  // events and derived levels
  wire req_edge    = handover_to_primary_request_i & ~req_q;
  wire hs_edge     = handshake_i ^ hs_in_q;
  wire peer_fail   = msg_fail_q | hs_fail_q;
  wire is_cmd      = (state_q == rhc_pkg::RHC_COMMAND);
  wire in_settle   = (state_q == rhc_pkg::RHC_SETTLE);
  wire in_release  = (state_q == rhc_pkg::RHC_RELEASE);
  wire in_watch    = (state_q == rhc_pkg::RHC_WATCH);
  wire frame_ok;
  wire hb_done;
  wire msg_done;
  wire msg_to_done;
  wire hs_to_done;
  wire role_done;
  wire go_settle;
  wire go_release;
  wire enter_cmd   = in_settle & role_done;
  wire tx_idle     = (tx_left_q == 5'h00);
  wire tx_tick     = ~tx_idle & (tx_cyc_q == 16'h0000);
  wire rx_tick     = rx_busy_q & (rx_cyc_q == 16'h0000);

  assign status_w = {23'h000000,
                     peer_bkp_q, peer_cmd_q, hs_fail_q, msg_fail_q,
                     sec_fail_q, rly_fault_q, io_enable_o, relay_q, is_cmd};
  assign rd_mux = (rd_addr == `RHC_OFS_CTRL)       ? {31'h00000000, role_bkp_q} :
                  (rd_addr == `RHC_OFS_ANOM_SELF)  ? {16'h0000, anom_self_q} :
                  (rd_addr == `RHC_OFS_ANOM_LOCAL) ? {16'h0000, anom_local_q} :
                  (rd_addr == `RHC_OFS_STATUS)     ? status_w :
                  (rd_addr == `RHC_OFS_ANOM_RX)    ? {16'h0000, anom_rx_q} :
                                                       32'h00000000;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_q;

  // address phase capture; read data loaded when the data phase begins
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end
    else
    begin
      dp_wr_q   <= in_map & hwrite_i & (hsize_i == 3'h2);
      dp_addr_q <= rd_addr;
    end
  end

  // read word taken at the address edge so it stands for the whole data phase
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_q <= 32'h00000000;
    else
      rdata_q <= rd_mux;
  end

  // heartbeat and message interval, free running from reset release
  rhc_timer u_hb (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .start_i (init_q | hb_done),
    .load_i  (P_HB_CYC),
    .busy_o  (),
    .done_o  (hb_done)
  );
  rhc_timer u_msg (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .start_i (init_q | msg_done),
    .load_i  (P_MSG_CYC),
    .busy_o  (),
    .done_o  (msg_done)
  );

  // peer watchdogs restart on every good frame or handshake transition
  rhc_timer u_msg_to (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .start_i (init_q | frame_ok),
    .load_i  (P_MSG_TO_CYC),
    .busy_o  (),
    .done_o  (msg_to_done)
  );
  rhc_timer u_hs_to (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .start_i (init_q | hs_edge),
    .load_i  (P_HS_TO_CYC),
    .busy_o  (),
    .done_o  (hs_to_done)
  );

  // one timer serves both the settling and the release transient
  rhc_timer u_role (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .start_i (go_settle | go_release),
    .load_i  (go_release ? P_RELEASE_CYC : P_SETTLE_CYC),
    .busy_o  (),
    .done_o  (role_done)
  );

  // input edge memories and peer failure flags
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      init_q     <= 1'b1;
      req_q      <= 1'b0;
      hs_in_q    <= 1'b0;
      hs_out_q   <= 1'b0;
      msg_fail_q <= 1'b0;
      hs_fail_q  <= 1'b0;
    end
    else
    begin
      init_q     <= 1'b0;
      req_q      <= handover_to_primary_request_i;
      hs_in_q    <= handshake_i;
      hs_out_q   <= hs_out_q ^ hb_done;
      msg_fail_q <= msg_to_done | (msg_fail_q & ~frame_ok);
      hs_fail_q  <= hs_to_done | (hs_fail_q & ~hs_edge);
    end
  end
  assign handshake_o = hs_out_q;

  // transmitter: start bit, role, state, local anomalies, stop bit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_sh_q   <= 20'hfffff;
      tx_left_q <= 5'h00;
      tx_cyc_q  <= 16'h0000;
    end
    else if (msg_done & tx_idle)
    begin
      tx_sh_q   <= {1'b1, anom_local_q, is_cmd, role_bkp_q, 1'b0};
      tx_left_q <= `RHC_FRAME_BITS;
      tx_cyc_q  <= `RHC_BIT_CYC - 16'h0001;
    end
    else if (tx_tick)
    begin
      tx_sh_q   <= {1'b1, tx_sh_q[19:1]};
      tx_left_q <= tx_left_q - 5'h01;
      tx_cyc_q  <= `RHC_BIT_CYC - 16'h0001;
    end
    else if (!tx_idle)
      tx_cyc_q  <= tx_cyc_q - 16'h0001;
  end
  assign link_tx_o = tx_sh_q[0];

  // receiver samples mid-bit; a bad stop bit drops the frame
  assign frame_ok = rx_tick & (rx_idx_q == `RHC_STOP_IDX) & link_rx_i;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_busy_q <= 1'b0;
      rx_idx_q  <= 5'h00;
      rx_cyc_q  <= 16'h0000;
      rx_sh_q   <= 18'h00000;
    end
    else if (!rx_busy_q)
    begin
      rx_busy_q <= ~link_rx_i;
      rx_idx_q  <= 5'h00;
      rx_cyc_q  <= `RHC_HALF_BIT_CYC;
    end
    else if (rx_tick)
    begin
      rx_busy_q <= ~((rx_idx_q == 5'h00) & link_rx_i) & (rx_idx_q != `RHC_STOP_IDX);
      rx_idx_q  <= rx_idx_q + 5'h01;
      rx_cyc_q  <= `RHC_BIT_CYC - 16'h0001;
      if (rx_idx_q != 5'h00)
        rx_sh_q <= {link_rx_i, rx_sh_q[17:1]};
    end
    else
      rx_cyc_q  <= rx_cyc_q - 16'h0001;
  end

  // peer view taken from each good frame
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      peer_bkp_q <= 1'b0;
      peer_cmd_q <= 1'b0;
      anom_rx_q  <= 16'h0000;
      rx_seen_q  <= 1'b0;
    end
    else if (frame_ok)
    begin
      peer_bkp_q <= rx_sh_q[0];
      peer_cmd_q <= rx_sh_q[1];
      anom_rx_q  <= rx_sh_q[17:2];
      rx_seen_q  <= 1'b1;
    end
  end

  // takeover: secondary on peer failure, primary on request or at start
  assign go_settle  = in_watch & (role_bkp_q ? peer_fail
                    : (req_edge
                    | (startup_q & (peer_fail | (rx_seen_q & ~peer_cmd_q)))));
  // release only by request and only from the commanding state
  assign go_release = role_bkp_q & is_cmd & req_edge;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      rhc_pkg::RHC_WATCH:
        if (go_settle)
          state_d = rhc_pkg::RHC_SETTLE;
      rhc_pkg::RHC_SETTLE:
        if (role_done)
          state_d = rhc_pkg::RHC_COMMAND;
      rhc_pkg::RHC_COMMAND:
        if (go_release)
          state_d = rhc_pkg::RHC_RELEASE;
        else if (!role_bkp_q & relay_fb_i & peer_cmd_q)
          state_d = rhc_pkg::RHC_WATCH;
      rhc_pkg::RHC_RELEASE:
        if (role_done)
          state_d = rhc_pkg::RHC_WATCH;
      default:
        state_d = rhc_pkg::RHC_WATCH;
    endcase
  end

  // role state, relay drive and configuration
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q    <= rhc_pkg::RHC_WATCH;
      relay_q    <= 1'b0;
      startup_q  <= 1'b1;
      role_bkp_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      relay_q    <= go_release ? 1'b0 : (relay_q | (go_settle & role_bkp_q));
      startup_q  <= startup_q & ~(in_watch & go_settle) & ~in_settle;
      role_bkp_q <= wr_ctrl ? hwdata_i[0] : role_bkp_q;
    end
  end
  assign changeover_relay_command_o = relay_q;

  // warnings are sticky; a new event beats a clear in the same cycle
  wire fb_wrong   = (relay_fb_i != role_bkp_q);
  wire rf_event   = (enter_cmd & fb_wrong)
                  | (in_release & role_done & relay_fb_i);
  wire sf_event   = ~role_bkp_q & peer_fail & relay_fb_i;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rly_fault_q <= 1'b0;
      sec_fail_q  <= 1'b0;
    end
    else
    begin
      rly_fault_q <= rf_event | (rly_fault_q & ~clr_rf);
      sec_fail_q  <= sf_event | (sec_fail_q & ~clr_sf);
    end
  end
  assign relay_feedback_fault_warning_o   = rly_fault_q;
  assign secondary_unit_failure_warning_o = sec_fail_q;

  // anomaly sets; software writes win over the hardware swap
  rhc_pkg::rhc_anom_t anom_local_d;
  assign anom_local_d = wr_local ? hwdata_i[15:0] : (enter_cmd ? anom_rx_q : anom_local_q);
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      anom_self_q  <= 16'h0000;
      anom_local_q <= 16'h0000;
    end
    else
    begin
      anom_self_q  <= wr_self  ? hwdata_i[15:0] : (enter_cmd ? 16'h0000 : anom_self_q);
      anom_local_q <= anom_local_d;
    end
  end

  // display and plant outputs from flops; switched I/O only once commanding
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      display_anom_o   <= 16'h0000;
      io_enable_o      <= 1'b0;
      fieldbus_tx_en_o <= 1'b0;
    end
    else
    begin
      display_anom_o   <= (state_d == rhc_pkg::RHC_COMMAND) ? anom_local_d : anom_self_q;
      io_enable_o      <= (state_d == rhc_pkg::RHC_COMMAND);
      fieldbus_tx_en_o <= (state_d == rhc_pkg::RHC_COMMAND);
    end
  end

  // helper: cycles spent in the settling state
  rhc_pkg::rhc_cnt_t settle_cnt_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      settle_cnt_q <= '0;
    else
      settle_cnt_q <= in_settle ? settle_cnt_q + rhc_pkg::rhc_cnt_t'(1) : '0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_release_relay_off: assert property (go_release |=> !changeover_relay_command_o)
    else $error("relay command still on after handover request");
  chk_release_fault: assert property (in_release && role_done && relay_fb_i |=> rly_fault_q)
    else $error("relay fault not raised after release transient");
  chk_release_to_watch: assert property (in_release && role_done |=> in_watch)
    else $error("secondary did not fall back to watching");
  chk_no_auto_return: assert property ($fell(relay_q) |-> $past(req_edge))
    else $error("relay command dropped without operator request");
  chk_settle_io_off: assert property (in_settle |-> !io_enable_o)
    else $error("switched io used during settling");
  chk_settle_length: assert property (enter_cmd |-> settle_cnt_q >= P_SETTLE_CYC - 1)
    else $error("settling shorter than required");
  chk_cmd_io_on: assert property (enter_cmd |=> io_enable_o && fieldbus_tx_en_o)
    else $error("commanding unit not driving plant");
  chk_sec_fail_warn: assert property (sf_event |=> sec_fail_q)
    else $error("secondary failure warning missing");
  chk_self_set_drop: assert property (enter_cmd && !wr_self |=> anom_self_q == 16'h0000)
    else $error("self anomaly set kept after taking command");
  chk_hb_toggle: assert property (hb_done |=> handshake_o != $past(handshake_o))
    else $error("handshake did not toggle");
  chk_hs_watchdog: assert property (hs_to_done |=> peer_fail)
    else $error("handshake loss not flagged");
  chk_watch_display: assert property (in_watch && $stable(state_q) [*2] |-> display_anom_o == $past(anom_self_q))
    else $error("watching unit displays wrong set");

  cov_release: cover property (go_release ##[1:1000] in_release);
  cov_takeover: cover property (in_watch && go_settle && role_bkp_q);
  cov_primary_return: cover property (in_watch && req_edge && !role_bkp_q);
  cov_frame: cover property (frame_ok);
endmodule

// *** sim/rhc_peer_model.sv ***
module rhc_peer_model (
  input  wire logic clk_i,
  input  wire logic relay_cmd_i,
  input  wire logic hs_run_i,
  input  wire logic stuck_i,
  output logic      handshake_o,
  output logic      link_rx_o,
  output logic      relay_fb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] hs_cnt = 5'h00;
  logic [3:0] fb_dly = 4'h0;
  logic       hs_q   = 1'b0;
  // peer heartbeat; stops when the bench wants a dead peer
  always @(posedge clk_i)
  begin
    if (hs_run_i)
    begin
      hs_cnt <= (hs_cnt == 5'h13) ? 5'h00 : hs_cnt + 5'h01;
      if (hs_cnt == 5'h13)
        hs_q <= ~hs_q;
    end
    fb_dly <= {fb_dly[2:0], relay_cmd_i};
  end
  // contact lags the coil; stuck models a welded contact
  assign relay_fb_o = stuck_i ? 1'b1 : fb_dly[3];
  assign handshake_o = hs_q;
  // no frames sent: the line rests at its idle mark level
  assign link_rx_o  = 1'b1;
endmodule

// *** sim/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i   = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        hsel_i  = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic        req     = 1'b0;
  logic        hs_run  = 1'b1;
  logic        stuck   = 1'b0;
  logic        hrdy, hresp, hs_in, hs_out, rx, tx, rly, fb, io, fbus, rly_flt, sec_flt;
  logic [31:0] hrdata;
  logic [15:0] disp;
  logic [31:0] r;
  int          error_cnt = 0;
  int          checks    = 0;
  int          n;

  always #25 clk_i = ~clk_i;

  // short counts keep the run small
  rhc_top #(
    .P_HB_CYC      (24'h000014),
    .P_HS_TO_CYC   (24'h000064),
    .P_SETTLE_CYC  (24'h000028),
    .P_RELEASE_CYC (24'h00003c)
  ) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .handover_to_primary_request_i(req), .relay_fb_i(fb), .handshake_i(hs_in),
    .link_rx_i(rx), .handshake_o(hs_out), .link_tx_o(tx),
    .changeover_relay_command_o(rly), .io_enable_o(io), .fieldbus_tx_en_o(fbus),
    .relay_feedback_fault_warning_o(rly_flt),
    .secondary_unit_failure_warning_o(sec_flt), .display_anom_o(disp)
  );

  rhc_peer_model u_peer (
    .clk_i(clk_i), .relay_cmd_i(rly), .hs_run_i(hs_run), .stuck_i(stuck),
    .handshake_o(hs_in), .link_rx_o(rx), .relay_fb_o(fb)
  );

  task print_verdict;
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // one single word transfer; holds each phase until hready is seen
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    do begin tick(1); k++; end while (hrdy !== 1'b1 && k < 16);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do begin tick(1); k++; end while (hrdy !== 1'b1 && k < 32);
    r = hrdata;
    if (k >= 16)
    begin
      error_cnt++;
      print_verdict;
    end
  endtask

  // bounded wait for io_enable to reach a level
  task wait_io(input logic v, input int lim);
    n = 0;
    while (io !== v && n < lim)
    begin
      tick(1);
      n++;
    end
    if (n >= lim)
    begin
      error_cnt++;
      print_verdict;
    end
  endtask

  task press;
    req <= 1'b1;
    tick(2);
  endtask

  task do_reset;
    rst_b_i <= 1'b0;
    req <= 1'b0;
    tick(5);
    rst_b_i <= 1'b1;
    tick(1);
  endtask

  task s_reset;
    chk({hrdy, hresp, tx, rly, io, rly_flt, sec_flt}, 32'h50);
    ahb(1'b0, 32'h0000000c, 32'h0);
    chk(r, 32'h0);
    ahb(1'b1, 32'h00000020, 32'hffffffff);
    ahb(1'b0, 32'h00000020, 32'h0);
    chk(r, 32'h0);
  endtask

  task s_heartbeat;
    logic last;
    last = hs_out;
    n = 0;
    while (hs_out === last && n < 40) begin tick(1); n++; end
    last = hs_out;
    n = 0;
    while (hs_out === last && n < 40) begin tick(1); n++; end
    chk(32'(n), 32'h14);
  endtask

  task s_secondary;
    ahb(1'b1, 32'h00000000, 32'h1);
    hs_run <= 1'b0;
    wait_io(1'b1, 600);
    chk(rly, 1'b1);
    hs_run <= 1'b1;
    stuck <= 1'b1;
    tick(30);
    press;
    chk(rly, 1'b0);
    req <= 1'b0;
    tick(45);
    chk(rly_flt, 1'b0);
    tick(25);
    chk(rly_flt, 1'b1);
    ahb(1'b0, 32'h0000000c, 32'h0);
    chk(r[0], 1'b0);
    stuck <= 1'b0;
    press;
    req <= 1'b0;
    tick(100);
    chk(rly, 1'b0);
    chk(io, 1'b0);
  endtask

  task s_primary;
    ahb(1'b1, 32'h00000004, 32'h00a5);
    ahb(1'b1, 32'h00000008, 32'h5a00);
    tick(2);
    chk(disp, 32'h00a5);
    press;
    wait_io(1'b1, 80);
    chk(32'(n >= 38 && n <= 43), 32'h1);
    chk({fbus, rly_flt}, 32'h2);
    chk(disp, 32'h0);
    ahb(1'b0, 32'h00000004, 32'h0);
    chk(r, 32'h0);
    req <= 1'b0;
    tick(3);
    press;
    req <= 1'b0;
    tick(60);
    chk(io, 1'b1);
  endtask

  task s_sec_fail;
    stuck <= 1'b1;
    hs_run <= 1'b0;
    n = 0;
    while (sec_flt !== 1'b1 && n < 400) begin tick(1); n++; end
    chk(sec_flt, 1'b1);
    chk(32'(n > 90), 32'h1);
  endtask

  initial
  begin
    do_reset;
    s_reset;
    s_heartbeat;
    s_secondary;
    do_reset;
    s_primary;
    do_reset;
    s_sec_fail;
    print_verdict;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    print_verdict;
  end
endmodule
